// file: dph_defines.svh
// timing, address and width constants for the dual-port ram host port
`ifndef DPH_DEFINES_SVH
`define DPH_DEFINES_SVH
`define DPH_AW          13
`define DPH_DW          16
`define DPH_BYTE_W      8
`define DPH_SEM_AW      3
`define DPH_MBOX_RIGHT  13'h1fff
`define DPH_MBOX_LEFT   13'h1ffe
`define DPH_CLK_NS      50
`define DPH_T_SD_NS     20
`define DPH_T_ACC_NS    55
`define DPH_T_DDD_NS    45
`define DPH_T_SOP_NS    20
`define DPH_T_BUSY_NS   45
`define DPH_SYNC_LAT    3
`define DPH_CNT_W       8
`define DPH_CNT_MAX     255
`define DPH_PIN_IDLE    1'b1
`define DPH_CNT_ONE     8'h01
`define DPH_CNT_ZERO    8'h00
`endif

// file: dph_dev_model.sv
// behavioural model of one ram port with a scripted opposite port
`timescale 1ns/1ps
`include "dph_defines.svh"
module dph_dev_model #(
  parameter int T_DDD_NS = 45,
  parameter int T_SD_NS  = 20
) (
  // clock for the float pattern
  input  wire logic                clk_i,
  // host pins
  input  wire dph_pkg::dph_ctl_s   ctl_i,
  input  wire logic [`DPH_AW-1:0]  addr_i,
  input  wire logic [`DPH_DW-1:0]  host_data_i,
  input  wire logic                host_oe_n_i,
  input  wire logic                busy_n_i,
  output logic [`DPH_DW-1:0]       bus_o,
  output logic                     int_n_o,
  output logic                     oth_int_n_o,
  // opposite port actions
  input  wire logic                oth_we_i,
  input  wire logic                oth_sem_i,
  input  wire logic [`DPH_AW-1:0]  oth_addr_i,
  input  wire logic [`DPH_DW-1:0]  oth_data_i
);
  import dph_pkg::*;
  logic [15:0] mem [0:8191];
  int          own [0:7];
  logic [7:0]  rq [1:2];
  logic [15:0] flt_q, rd_v, msk_v;
  realtime     t_chg;
  logic        ok;
  initial begin
    flt_q = 16'h5a3c;
    int_n_o = 1'b1;
    oth_int_n_o = 1'b1;
    rq[1] = 8'h00;
    rq[2] = 8'h00;
    t_chg = 0;
    foreach (own[i]) own[i] = 0;
  end
  // released lines show a pattern that flips every cycle
  always @(posedge clk_i) flt_q <= ~flt_q;
  always @(host_data_i) t_chg = $realtime;
  // one owner, waiting side takes over on release
  task automatic sem_wr(input int me, input logic [2:0] i, input logic v);
    if (!v && own[i] == 0) own[i] = me;
    else if (!v) rq[me][i] = (own[i] != me);
    else if (own[i] == me) begin
      own[i] = rq[3-me][i] ? 3 - me : 0;
      rq[3-me][i] = 1'b0;
    end else rq[me][i] = 1'b0;
  endtask : sem_wr
  always @(posedge ctl_i.rw_n) begin
    ok = !host_oe_n_i && ($realtime - t_chg >= T_SD_NS);
    if (!ctl_i.sem_n) sem_wr(1, addr_i[2:0], host_data_i[0]);
    else if (!ctl_i.ce_n) begin
      if (!ctl_i.lower_byte_select_n) mem[addr_i][7:0] = ok ? host_data_i[7:0] : 'x;
      if (!ctl_i.upper_byte_select_n) mem[addr_i][15:8] = ok ? host_data_i[15:8] : 'x;
      if (addr_i == `DPH_MBOX_RIGHT && busy_n_i) oth_int_n_o = 1'b0;
    end
  end
  // far write lands after the flow-through delay
  always @(posedge oth_we_i) begin
    if (oth_addr_i == `DPH_MBOX_LEFT) int_n_o = 1'b0;
    mem[oth_addr_i] <= #(T_DDD_NS) oth_data_i;
  end
  always @(posedge oth_sem_i) sem_wr(2, oth_addr_i[2:0], oth_data_i[0]);
  // only an unblocked read of the own mailbox clears
  // level sensitive so pins that change in one step are seen settled
  always @(ctl_i or addr_i or busy_n_i)
    if (!ctl_i.oe_n && !ctl_i.ce_n && ctl_i.rw_n && addr_i == `DPH_MBOX_LEFT && busy_n_i) int_n_o = 1'b1;
  // lanes driven only when selected and enabled
  always_comb begin
    msk_v = 16'h0000;
    rd_v = mem[addr_i];
    if (!ctl_i.oe_n && ctl_i.rw_n && !ctl_i.sem_n) begin
      rd_v = {16{own[addr_i[2:0]] != 1}};
      msk_v = 16'hffff;
    end else if (!ctl_i.oe_n && ctl_i.rw_n && !ctl_i.ce_n)
      msk_v = {{8{!ctl_i.upper_byte_select_n}}, {8{!ctl_i.lower_byte_select_n}}};
  end
  assign bus_o = !host_oe_n_i ? host_data_i : (rd_v & msk_v) | (flt_q & ~msk_v);
endmodule : dph_dev_model

// file: dph_host.sv
// host-side controller that drives one port of an asynchronous dual-port ram
// Function
// R1: write ends on rising read/write strobe with data held for setup time.
// R2: opposite-port write data valid only after the flow-through delay.
// R3: memory read needs chip select and output enable low; semaphore uses strobe.
// R4: top word is right mailbox, next word the left mailbox.
// R5: writing the other port's mailbox raises that port's interrupt flag.
// R6: owner reading its mailbox clears its interrupt flag.
// R7: reading the other mailbox leaves its interrupt pending.
// R8: active busy blocks mailbox interrupt set and clear for that port.
// R9: device grants a contended location to exactly one port.
// R10: loser's busy asserts a fixed delay after match or select.
// R11: master drives busy as outputs, slave takes busy as inputs.
// R12: host delays writes until busy has settled and is inactive; semaphore writes wait the settle time but ignore busy.
// R13: eight semaphores addressed by three low address lines only.
// R14: chip select stays high while semaphore strobe is low.
// R15: semaphore write uses only data line zero.
// R16: writing zero to free semaphore gives ownership, other side reads one.
// R17: owner writing one frees it or passes it to a waiting port.
// R18: semaphore read drives its value on all lines, latched.
// R19: simultaneous semaphore requests give it to exactly one port.
// R20: after semaphore write, strobe and output enable stay high before read-back.
// R21: byte selects gate the upper and lower data lanes.
// R22: deselect or output enable high floats all data lines.
`timescale 1ns/1ps
`include "dph_defines.svh"
module dph_host #(
  parameter int T_SD_NS   = `DPH_T_SD_NS,
  parameter int T_ACC_NS  = `DPH_T_ACC_NS,
  parameter int T_DDD_NS  = `DPH_T_DDD_NS,
  parameter int T_SOP_NS  = `DPH_T_SOP_NS,
  parameter int T_BUSY_NS = `DPH_T_BUSY_NS
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // command port
  input  wire logic                  req_valid_i,
  input  wire dph_pkg::dph_cmd_s     req_cmd_i,
  output logic                       req_ready_o,
  output logic                       rsp_valid_o,
  output logic [`DPH_DW-1:0]         rsp_data_o,
  output logic                       int_pending_o,
  // ram port pins
  output dph_pkg::dph_ctl_s          ctl_o,
  output logic [`DPH_AW-1:0]         addr_o,
  output logic [`DPH_DW-1:0]         data_o,
  output logic                       data_oe_n_o,
  input  wire logic [`DPH_DW-1:0]    data_i,
  input  wire logic                  busy_n_i,
  input  wire logic                  int_n_i
);
  import dph_pkg::*;

  localparam int CLK = `DPH_CLK_NS;
  localparam int SETUP_CYC = (T_SD_NS + CLK - 1) / CLK < 1 ? 1 : (T_SD_NS + CLK - 1) / CLK;
  localparam int BUSY_CYC  = (T_BUSY_NS + CLK - 1) / CLK + `DPH_SYNC_LAT;
  localparam int SOP_CYC   = (T_SOP_NS + CLK - 1) / CLK < 1 ? 1 : (T_SOP_NS + CLK - 1) / CLK;
  localparam int RD_CYC    = (T_ACC_NS + T_DDD_NS + CLK - 1) / CLK + `DPH_SYNC_LAT;
  localparam logic [`DPH_CNT_W-1:0] SETUP_LD = `DPH_CNT_W'(SETUP_CYC - 1);
  localparam logic [`DPH_CNT_W-1:0] BUSY_LD  = `DPH_CNT_W'(BUSY_CYC - 1);
  localparam logic [`DPH_CNT_W-1:0] SOP_LD   = `DPH_CNT_W'(SOP_CYC - 1);
  localparam logic [`DPH_CNT_W-1:0] RD_LD    = `DPH_CNT_W'(RD_CYC - 1);

  if (SETUP_CYC > `DPH_CNT_MAX || BUSY_CYC > `DPH_CNT_MAX || SOP_CYC > `DPH_CNT_MAX ||
      RD_CYC > `DPH_CNT_MAX) begin : g_chk
    $error("dph_host: timing count exceeds counter width");
  end

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WRITE, S_WEND, S_READ, S_RECOV} dph_state_e;

  dph_state_e              state_q, state_d;
  dph_ctl_s                ctl_q, ctl_d;
  dph_kind_e               kind_q, kind_d;
  logic [`DPH_AW-1:0]      addr_q, addr_d;
  logic [`DPH_DW-1:0]      wdata_q, wdata_d;
  logic                    doe_n_q, doe_n_d;
  logic [`DPH_CNT_W-1:0]   cnt_q, cnt_d;
  logic                    rsp_v_q, rsp_v_d;
  logic [`DPH_DW-1:0]      rsp_q, rsp_d;
  logic [`DPH_CNT_W-1:0]   wr_len_q, wr_len_d;
  logic                    busy_n_s;
  logic                    int_n_s;
  logic [`DPH_DW-1:0]      data_s;
  logic                    is_sem;
  logic                    ready_q, ready_d;
  logic                    int_q, int_d;

  dph_sync #(.W(2), .RST_VAL(2'h3)) u_flag_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({busy_n_i, int_n_i}),
    .q_o     ({busy_n_s, int_n_s})
  );

  // read data waits out the access time, so all three flops have settled
  dph_sync #(.W(`DPH_DW), .RST_VAL('0)) u_data_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (data_i),
    .q_o     (data_s)
  );

  assign is_sem = (kind_q == DPH_SEM_RD) || (kind_q == DPH_SEM_WR);

  always_comb begin
    state_d  = state_q;
    ctl_d    = ctl_q;
    kind_d   = kind_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    doe_n_d  = doe_n_q;
    cnt_d    = (cnt_q != `DPH_CNT_ZERO) ? cnt_q - `DPH_CNT_ONE : cnt_q;
    rsp_v_d  = 1'b0;
    rsp_d    = rsp_q;
    wr_len_d = ctl_q.rw_n ? `DPH_CNT_ZERO : wr_len_q + `DPH_CNT_ONE;
    case (state_q)
      S_IDLE: begin
        // ready gates the take, so nothing is accepted while ready is still low after reset
        if (req_valid_i && ready_q) begin
          kind_d  = req_cmd_i.kind;
          wdata_d = req_cmd_i.wdata;
          addr_d  = req_cmd_i.addr;
          // semaphores use only the low address lines
          // R13: semaphore addressing
          if (req_cmd_i.kind == DPH_SEM_RD || req_cmd_i.kind == DPH_SEM_WR) begin
            addr_d = {{(`DPH_AW-`DPH_SEM_AW){1'b0}}, req_cmd_i.addr[`DPH_SEM_AW-1:0]};
          end
          // R14: chip select high during semaphore access
          ctl_d.ce_n  = (req_cmd_i.kind == DPH_SEM_RD || req_cmd_i.kind == DPH_SEM_WR);
          ctl_d.sem_n = !ctl_d.ce_n;
          // R21: byte selects; semaphore access keeps both high
          ctl_d.upper_byte_select_n = !(req_cmd_i.upper_en && !ctl_d.ce_n);
          ctl_d.lower_byte_select_n = !(req_cmd_i.lower_en && !ctl_d.ce_n);
          if (req_cmd_i.kind == DPH_MEM_RD || req_cmd_i.kind == DPH_SEM_RD) begin
            // R3: read asserts select and output enable together
            ctl_d.oe_n = 1'b0;
            cnt_d      = RD_LD;
            state_d    = S_READ;
          end else begin
            cnt_d   = BUSY_LD;
            state_d = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        // R12: memory writes wait for busy to settle and go inactive
        if (cnt_q == `DPH_CNT_ZERO && (is_sem || busy_n_s)) begin
          ctl_d.rw_n = 1'b0;
          doe_n_d    = 1'b0;
          cnt_d      = SETUP_LD;
          state_d    = S_WRITE;
        end
      end
      S_WRITE: begin
        // R1: rising strobe only after data held for setup time
        if (cnt_q == `DPH_CNT_ZERO) begin
          ctl_d.rw_n = 1'b1;
          state_d    = S_WEND;
        end
      end
      S_WEND: begin
        // data held one cycle past the rising strobe, then everything floats
        ctl_d.ce_n                = `DPH_PIN_IDLE;
        ctl_d.sem_n               = `DPH_PIN_IDLE;
        ctl_d.upper_byte_select_n = `DPH_PIN_IDLE;
        ctl_d.lower_byte_select_n = `DPH_PIN_IDLE;
        doe_n_d                   = 1'b1;
        if (is_sem) begin
          cnt_d   = SOP_LD;
          state_d = S_RECOV;
        end else begin
          rsp_v_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_READ: begin
        // R2: sample only after access plus flow-through delay
        if (cnt_q == `DPH_CNT_ZERO) begin
          rsp_d                     = data_s;
          rsp_v_d                   = 1'b1;
          ctl_d.ce_n                = `DPH_PIN_IDLE;
          ctl_d.sem_n               = `DPH_PIN_IDLE;
          ctl_d.oe_n                = `DPH_PIN_IDLE;
          ctl_d.upper_byte_select_n = `DPH_PIN_IDLE;
          ctl_d.lower_byte_select_n = `DPH_PIN_IDLE;
          state_d                   = S_IDLE;
        end
      end
      S_RECOV: begin
        // R20: strobe and output enable held high before any read-back
        if (cnt_q == `DPH_CNT_ZERO) begin
          rsp_v_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q  <= S_IDLE;
      ctl_q    <= '1;
      kind_q   <= DPH_MEM_RD;
      addr_q   <= '0;
      wdata_q  <= '0;
      doe_n_q  <= 1'b1;
      cnt_q    <= '0;
      rsp_v_q  <= 1'b0;
      rsp_q    <= '0;
      wr_len_q <= '0;
    end else begin
      state_q  <= state_d;
      ctl_q    <= ctl_d;
      kind_q   <= kind_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      doe_n_q  <= doe_n_d;
      cnt_q    <= cnt_d;
      rsp_v_q  <= rsp_v_d;
      rsp_q    <= rsp_d;
      wr_len_q <= wr_len_d;
    end
  end

  always_comb begin
    ready_d = (state_d == S_IDLE);
    int_d   = !int_n_s;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      int_q   <= 1'b0;
    end else begin
      ready_q <= ready_d;
      int_q   <= int_d;
    end
  end

  assign req_ready_o   = ready_q;
  assign rsp_valid_o   = rsp_v_q;
  assign rsp_data_o    = rsp_q;
  assign int_pending_o = int_q;
  assign ctl_o         = ctl_q;
  assign addr_o        = addr_q;
  assign data_o        = wdata_q;
  assign data_oe_n_o   = doe_n_q;

  sequence strobe_low_s;
    !ctl_q.rw_n && !doe_n_q;
  endsequence

  sequence data_held_s;
    !doe_n_q;
  endsequence

  sel_excl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
    !(!ctl_q.ce_n && !ctl_q.sem_n)) else $error("chip select and semaphore strobe both low");

  rd_enables_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    (state_q == S_READ) |-> !ctl_q.oe_n && (ctl_q.ce_n != ctl_q.sem_n))
    else $error("read without output enable and one select");

  wr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    $rose(ctl_q.rw_n) |-> !doe_n_q && (wr_len_q >= `DPH_CNT_W'(SETUP_CYC)))
    else $error("write strobe ended before data setup time");

  wr_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    $fell(ctl_q.rw_n) |-> strobe_low_s ##1 data_held_s)
    else $error("write strobe without driven data");

  busy_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    $fell(ctl_q.rw_n) && !ctl_q.ce_n |-> $past(busy_n_s))
    else $error("memory write started while busy");

  sem_recov_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R20
    $rose(ctl_q.sem_n) && $past(kind_q == DPH_SEM_WR) |-> (ctl_q.sem_n && ctl_q.oe_n) [*2])
    else $error("semaphore read-back too soon");

  rd_float_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R22
    !ctl_q.oe_n |-> doe_n_q) else $error("host drives data while output enable low");

  sem_lanes_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    !ctl_q.sem_n |-> addr_q[`DPH_AW-1:`DPH_SEM_AW] == '0 && ctl_q.upper_byte_select_n
    && ctl_q.lower_byte_select_n) else $error("semaphore access with upper address or byte select");

  rsp_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    $fell(ctl_q.oe_n) |-> !rsp_v_q [*2]) else $error("read answered before access time");
endmodule : dph_host

// file: dph_pkg.sv
// types shared by the dual-port ram host port
`include "dph_defines.svh"
package dph_pkg;
  typedef enum logic [1:0] {
    DPH_MEM_RD,
    DPH_MEM_WR,
    DPH_SEM_RD,
    DPH_SEM_WR
  } dph_kind_e;

  typedef struct packed {
    dph_kind_e                kind;
    logic [`DPH_AW-1:0]       addr;
    logic [`DPH_DW-1:0]       wdata;
    logic                     upper_en;
    logic                     lower_en;
  } dph_cmd_s;

  typedef struct packed {
    logic                     ce_n;
    logic                     rw_n;
    logic                     oe_n;
    logic                     sem_n;
    logic                     upper_byte_select_n;
    logic                     lower_byte_select_n;
  } dph_ctl_s;
endpackage : dph_pkg

// file: dph_sync.sv
// three-flop input synchroniser that takes a change once the last two flops agree
`timescale 1ns/1ps
module dph_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  always_comb begin
    q_d = (s2_q == s3_q) ? s3_q : q_o;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= q_d;
    end
  end
endmodule : dph_sync

// file: dual_port_ram_arbiter_sem_tb.sv
// self-checking bench for the dual-port ram host port
`timescale 1ns/1ps
`include "dph_defines.svh"
module dual_port_ram_arbiter_sem_tb;
  import dph_pkg::*;
  logic clk_i, rst_n_i, req_valid_i, req_ready_o, rsp_valid_o, int_pending_o;
  logic data_oe_n_o, busy_n_i, int_n, oth_int_n, oth_we, oth_sem;
  dph_cmd_s                req_cmd_i;
  dph_ctl_s                ctl_o;
  logic [`DPH_AW-1:0]      addr_o, oth_addr;
  logic [`DPH_DW-1:0]      rsp_data_o, data_o, bus, oth_data, rd;
  int                      num_errors, samples_checked;
  dph_host dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .int_pending_o(int_pending_o), .ctl_o(ctl_o), .addr_o(addr_o), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .data_i(bus), .busy_n_i(busy_n_i), .int_n_i(int_n));
  dph_dev_model u_dev (.clk_i(clk_i), .ctl_i(ctl_o), .addr_i(addr_o), .host_data_i(data_o),
    .host_oe_n_i(data_oe_n_o), .busy_n_i(busy_n_i), .bus_o(bus), .int_n_o(int_n),
    .oth_int_n_o(oth_int_n), .oth_we_i(oth_we), .oth_sem_i(oth_sem), .oth_addr_i(oth_addr),
    .oth_data_i(oth_data));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic run(input dph_kind_e k, input logic [12:0] a, input logic [15:0] d, input logic [1:0] en);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= '{k, a, d, en[1], en[0]};
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    while (rsp_valid_o !== 1'b1) @(posedge clk_i);
    rd = rsp_data_o;
  endtask : run
  task automatic oth(input logic [12:0] a, input logic [15:0] d, input logic sem);
    @(posedge clk_i);
    oth_addr <= a;
    oth_data <= d;
    oth_we <= !sem;
    oth_sem <= sem;
    @(posedge clk_i);
    oth_we <= 1'b0;
    oth_sem <= 1'b0;
  endtask : oth
  task automatic s_mem;
    run(DPH_MEM_WR, 13'h0005, 16'h1234, 2'b11);
    run(DPH_MEM_RD, 13'h0005, 16'h0000, 2'b11);
    chk("read both", 16'h1234, rd);
    run(DPH_MEM_WR, 13'h0005, 16'hab99, 2'b10);
    run(DPH_MEM_RD, 13'h0005, 16'h0000, 2'b11);
    chk("upper only write", 16'hab34, rd);
    run(DPH_MEM_RD, 13'h0005, 16'h0000, 2'b01);
    chk("lower lane read", 16'h0034, {8'h00, rd[7:0]});
    oth(13'h0200, 16'h5a5a, 1'b0);
    run(DPH_MEM_RD, 13'h0200, 16'h0000, 2'b11);
    chk("far write seen", 16'h5a5a, rd);
  endtask : s_mem
  task automatic s_busy;
    logic lo;
    lo = 1'b0;
    busy_n_i <= 1'b0;
    fork
      run(DPH_MEM_WR, 13'h0100, 16'hbeef, 2'b11);
      begin
        repeat (20) begin
          @(posedge clk_i);
          lo = lo | !ctl_o.rw_n;
        end
        chk("write held off", 16'h0000, lo);
        busy_n_i <= 1'b1;
      end
    join
    run(DPH_MEM_RD, 13'h0100, 16'h0000, 2'b11);
    chk("late write", 16'hbeef, rd);
  endtask : s_busy
  task automatic s_mbox;
    oth(`DPH_MBOX_LEFT, 16'h0042, 1'b0);
    repeat (6) @(posedge clk_i);
    chk("int raised", 16'h0001, int_pending_o);
    run(DPH_MEM_RD, `DPH_MBOX_RIGHT, 16'h0000, 2'b11);
    repeat (6) @(posedge clk_i);
    chk("int kept", 16'h0001, int_pending_o);
    busy_n_i <= 1'b0;
    run(DPH_MEM_RD, `DPH_MBOX_LEFT, 16'h0000, 2'b11);
    busy_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("int kept busy", 16'h0001, int_pending_o);
    run(DPH_MEM_RD, `DPH_MBOX_LEFT, 16'h0000, 2'b11);
    chk("mailbox data", 16'h0042, rd);
    repeat (6) @(posedge clk_i);
    chk("int cleared", 16'h0000, int_pending_o);
    run(DPH_MEM_WR, `DPH_MBOX_RIGHT, 16'h0077, 2'b11);
    chk("far int raised", 16'h0000, oth_int_n);
  endtask : s_mbox
  task automatic s_sem;
    run(DPH_SEM_WR, 13'h1ffb, 16'hfffe, 2'b11);
    run(DPH_SEM_RD, 13'h0003, 16'h0000, 2'b00);
    chk("sem taken", 16'h0000, rd);
    oth(13'h0003, 16'h0000, 1'b1);
    run(DPH_SEM_WR, 13'h0003, 16'h0001, 2'b00);
    run(DPH_SEM_RD, 13'h0003, 16'h0000, 2'b00);
    chk("sem passed", 16'hffff, rd);
    run(DPH_SEM_WR, 13'h0003, 16'h0000, 2'b00);
    run(DPH_SEM_RD, 13'h0003, 16'h0000, 2'b00);
    chk("sem refused", 16'hffff, rd);
    oth(13'h0003, 16'h0001, 1'b1);
    run(DPH_SEM_WR, 13'h0003, 16'h0000, 2'b00);
    run(DPH_SEM_RD, 13'h0003, 16'h0000, 2'b00);
    chk("sem retaken", 16'h0000, rd);
  endtask : s_sem
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_cmd_i = '0;
    busy_n_i = 1'b1;
    oth_we = 1'b0;
    oth_sem = 1'b0;
    oth_addr = '0;
    oth_data = '0;
    num_errors = 0;
    samples_checked = 0;
    // reset reaches every synchroniser flop at its first edge
    repeat (3) @(posedge clk_i);
    chk("pins at rest", 16'h003f, ctl_o);
    chk("data released", 16'h0001, data_oe_n_o);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("ready after reset", 16'h0001, req_ready_o);
    s_mem;
    s_busy;
    s_mbox;
    s_sem;
    test_done;
  end
  initial begin
    #(4000 * 50);
    num_errors++;
    test_done;
  end
endmodule : dual_port_ram_arbiter_sem_tb
